// File: adssq_chan_bank.v
// per-channel input registers: one write port from the sequencer, one read index
`timescale 1ns/10ps
module adssq_chan_bank #(
   parameter NCH = 16,
   parameter AW  = 4
) (
   // clock and reset
   input  wire          ref_clk,
   input  wire          srst,
   // write side
   input  wire          wr_en,
   input  wire [AW-1:0] wr_idx,
   input  wire [15:0]   wr_data,
   // read side
   input  wire [AW-1:0] rd_idx,
   output wire [15:0]   rd_data
);

   reg [15:0] mem_reg [0:NCH-1];
   integer    i;

   // R04 independent read port
   assign rd_data = mem_reg[rd_idx];

   always @(posedge ref_clk) begin
      if (srst) begin
         for (i = 0; i < NCH; i = i + 1) begin
            mem_reg[i] <= 16'h0000;
         end
      end else if (wr_en) begin
         // R03 newest sample overwrites
         mem_reg[wr_idx] <= wr_data;
      end
   end

endmodule // adssq_chan_bank

// File: adssq_conv_model.sv
// converter model answering each start pulse after a fixed delay
`timescale 1ns/10ps
module adssq_conv_model #(
   parameter DLY = 4
) (
   // clock
   input  wire        ref_clk,
   // converter link
   input  wire        conv_start,
   input  wire [3:0]  conv_chan,
   input  wire [11:0] base,
   output reg         conv_done,
   output reg  [11:0] conv_data
);
   integer cnt = 0;
   initial begin
      conv_done = 1'b0;
      conv_data = 12'h000;
   end
   always @(posedge ref_clk) begin
      conv_done <= 1'b0;
      // data is only valid with the done pulse
      conv_data <= ~conv_data;
      if (conv_start === 1'b1)
         cnt <= DLY;
      else if (cnt == 1) begin
         cnt <= 0;
         conv_done <= 1'b1;
         conv_data <= base ^ {8'h00, conv_chan};
      end else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule // adssq_conv_model

// File: adssq_fmt.v
// converts an offset-binary converter code to the selected output format
`timescale 1ns/10ps
module adssq_fmt #(
   parameter DW = 12
) (
   // raw code and format select
   input  wire [DW-1:0] raw_code,
   input  wire          offset_bin,
   // formatted 16-bit word
   output reg  [15:0]   fmt_word
);

   reg [DW-1:0] twos;

   always @* begin
      twos = raw_code;
      // R20 top bit inverted
      twos[DW-1] = ~raw_code[DW-1];
      // R21 format select
      if (offset_bin) begin
         // R19 zero top bits
         fmt_word = {{(16-DW){1'b0}}, raw_code};
      end else begin
         // R19 sign extension
         fmt_word = {{(16-DW){twos[DW-1]}}, twos};
      end
   end

endmodule // adssq_fmt

// File: adssq_regs.vh
// register offsets, field positions and reset values of the scan sequencer
//
// Operation
// R01 - reset or both mode bits zero: free-running scan
// R02 - free-running scan ascends, wraps to channel zero
// R03 - each scanned result overwrites its channel register
// R04 - channel registers readable anytime, scan not stalled
// R05 - host clears both mode bits for free-running
// R06 - single-pass scan converts each channel once, stops
// R07 - single-pass completion raises end-of-scan flag
// R08 - host writes mode high one, low zero
// R09 - scan length register at 06, values 0..10h
// R10 - length N scans 0..N-1, zero acts as one
// R11 - reset scan length covers sixteen channels
// R12 - host loads scan length before single-pass start
// R13 - halt forces sixteen channels, blocks length writes
// R14 - channel select plus start converts that channel
// R15 - single conversion completion sets data-ready flag
// R16 - host waits conversion time before testing ready
// R17 - host writes mode high zero, low one
// R18 - polling result in read-only register at 04
// R19 - top nibble zero, or sign in two's complement
// R20 - two's complement inverts the result's top bit
// R21 - format bit zero two's complement, one offset
// R22 - halt stops sequencer until software clears it
// R23 - start bit write starts, read shows done
// R24 - both mode bits set selects no conversion
// R25 - starting a conversion clears stale completion flags
// R26 - start ignored while a sequence is running

`ifndef ADSSQ_REGS_VH
`define ADSSQ_REGS_VH

// byte offsets
`define ADSSQ_OFS_CTRL       7'h02
`define ADSSQ_OFS_RESULT     7'h04
`define ADSSQ_OFS_SCAN_LEN   7'h06
`define ADSSQ_OFS_CHAN_BASE  7'h40
`define ADSSQ_OFS_CHAN_LAST  7'h5e

// control_status_word fields
`define ADSSQ_BIT_READY      15
`define ADSSQ_BIT_FAIL_LED   14
`define ADSSQ_BIT_START      13
`define ADSSQ_BIT_FORMAT     12
`define ADSSQ_BIT_ONLINE     11
`define ADSSQ_BIT_TEST_HI    10
`define ADSSQ_BIT_TEST_LO    9
`define ADSSQ_BIT_FAST       8
`define ADSSQ_BIT_OP_HI      7
`define ADSSQ_BIT_SETTLE     6
`define ADSSQ_BIT_HALT       5
`define ADSSQ_BIT_OP_LO      4

// operating modes {op_select_hi, op_select_lo}
`define ADSSQ_OP_AUTO        2'b00
`define ADSSQ_OP_POLL        2'b01
`define ADSSQ_OP_SINGLE      2'b10

// reset values
`define ADSSQ_CTRL_RESET     16'h0000
`define ADSSQ_SCAN_LEN_FULL  5'h10
`define ADSSQ_SCAN_LEN_MAX   16'h0010

`endif

// File: adssq_seq.v
// scan sequencer top: control/status, scan length, result register and channel bank
`timescale 1ns/10ps
`include "adssq_regs.vh"
module adssq_seq #(
   parameter DW  = 12,
   parameter NCH = 16
) (
   // clock and reset
   input  wire          ref_clk,
   input  wire          srst,
   // register port, byte offsets, 16-bit words
   input  wire [6:0]    bus_addr,
   input  wire          bus_wr,
   input  wire          bus_rd,
   input  wire [15:0]   bus_wdata,
   output reg  [15:0]   bus_rdata,
   output reg           bus_rvalid,
   // converter handshake
   output reg           conv_start,
   output reg  [3:0]    conv_chan,
   input  wire          conv_done,
   input  wire [DW-1:0] conv_data,
   output reg           settle_req,
   // status and board controls
   output wire          conv_busy,
   output wire          fail_led_on,
   output wire          outputs_online,
   output wire [1:0]    test_mode,
   output wire          fast_refresh,
   output wire          short_settle
);

   // sequencer states
   localparam ST_IDLE  = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_WAIT  = 2'd2;

   // sequence kinds
   localparam KIND_AUTO   = 2'd0;
   localparam KIND_SINGLE = 2'd1;
   localparam KIND_POLL   = 2'd2;

   // registers
   reg [15:0] ctrl_reg;
   reg [15:0] ctrl_next;
   reg [4:0]  scan_len_reg;
   reg [4:0]  scan_len_next;
   reg [15:0] result_reg;
   reg [15:0] result_next;
   reg        ready_reg;
   reg        ready_next;
   reg        scan_done_reg;
   reg        scan_done_next;
   reg [1:0]  state_reg;
   reg [1:0]  state_next;
   reg [1:0]  kind_reg;
   reg [1:0]  kind_next;
   reg [3:0]  chan_reg;
   reg [3:0]  chan_next;
   reg        conv_start_next;
   reg [3:0]  conv_chan_next;
   reg        settle_next;
   reg        store_en;

   // decoded fields
   wire       halt;
   wire [1:0] op_mode;
   wire       offset_bin;
   wire [3:0] last_chan;
   wire       wr_ctrl;
   wire       wr_len;
   wire       start_cmd;
   wire       chan_hit;
   wire [3:0] rd_idx;
   wire [15:0] chan_rd_data;
   wire [15:0] fmt_word;
   wire [15:0] ctrl_view;
   wire [15:0] len_view;
   wire       start_single;
   wire       start_poll;
   reg  [15:0] rd_word;

   // last channel of a scan of length n; zero counts as one
   function [3:0] last_of;
      input [4:0] n;
      begin
         if (n == 5'd0) begin
            last_of = 4'd0;
         end else begin
            last_of = n[3:0] - 4'd1;
         end
      end
   endfunction

   // true for an offset inside the channel register window
   function in_chan_win;
      input [6:0] a;
      begin
         in_chan_win = (a >= `ADSSQ_OFS_CHAN_BASE) && (a <= `ADSSQ_OFS_CHAN_LAST);
      end
   endfunction

   // operating mode pair {op_select_hi, op_select_lo} of a control word
   function [1:0] mode_of;
      input [15:0] w;
      begin
         mode_of = {w[`ADSSQ_BIT_OP_HI], w[`ADSSQ_BIT_OP_LO]};
      end
   endfunction

   assign halt       = ctrl_reg[`ADSSQ_BIT_HALT];
   assign op_mode    = mode_of(ctrl_reg);
   assign offset_bin = ctrl_reg[`ADSSQ_BIT_FORMAT];
   // R10 zero behaves as one
   assign last_chan  = last_of(scan_len_reg);
   assign wr_ctrl    = bus_wr && (bus_addr == `ADSSQ_OFS_CTRL);
   assign wr_len     = bus_wr && (bus_addr == `ADSSQ_OFS_SCAN_LEN);
   assign start_cmd  = wr_ctrl && bus_wdata[`ADSSQ_BIT_START];
   // a start counts only with a matching mode pair in the same write
   assign start_single = start_cmd && (mode_of(bus_wdata) == `ADSSQ_OP_SINGLE);
   assign start_poll   = start_cmd && (mode_of(bus_wdata) == `ADSSQ_OP_POLL);
   assign chan_hit   = in_chan_win(bus_addr);
   assign rd_idx     = bus_addr[4:1];
   assign conv_busy  = (state_reg != ST_IDLE);

   // board controls held in the control word
   assign fail_led_on    = ~ctrl_reg[`ADSSQ_BIT_FAIL_LED];
   assign outputs_online = ctrl_reg[`ADSSQ_BIT_ONLINE];
   assign test_mode      = ctrl_reg[`ADSSQ_BIT_TEST_HI:`ADSSQ_BIT_TEST_LO];
   assign fast_refresh   = ctrl_reg[`ADSSQ_BIT_FAST];
   assign short_settle   = ctrl_reg[`ADSSQ_BIT_READY];

   // R23 start bit reads as scan finished
   assign ctrl_view = {ready_reg, ctrl_reg[14], scan_done_reg, ctrl_reg[12:7], 1'b0, ctrl_reg[5:0]};

   // R13 halted length reads sixteen, also in the cycle before the force lands
   assign len_view = halt ? `ADSSQ_SCAN_LEN_MAX : {11'h000, scan_len_reg};

   adssq_fmt #(
      .DW (DW)
   ) u_fmt (
      .raw_code   (conv_data),
      .offset_bin (offset_bin),
      .fmt_word   (fmt_word)
   );

   adssq_chan_bank #(
      .NCH (NCH),
      .AW  (4)
   ) u_bank (
      .ref_clk (ref_clk),
      .srst    (srst),
      .wr_en   (store_en),
      .wr_idx  (conv_chan),
      .wr_data (fmt_word),
      .rd_idx  (rd_idx),
      .rd_data (chan_rd_data)
   );

   // control word and scan length
   always @* begin
      ctrl_next     = ctrl_reg;
      scan_len_next = scan_len_reg;
      settle_next   = 1'b0;
      if (wr_ctrl) begin
         // R01 mode bits written by software
         ctrl_next = bus_wdata;
         // start and settle act on the write only, never stored
         ctrl_next[`ADSSQ_BIT_START]  = 1'b0;
         ctrl_next[`ADSSQ_BIT_SETTLE] = 1'b0;
         settle_next = bus_wdata[`ADSSQ_BIT_SETTLE];
      end
      if (halt) begin
         // R13 halt forces full length
         scan_len_next = `ADSSQ_SCAN_LEN_FULL;
      end else if (wr_len) begin
         // R09 accepts 0..10h
         if (bus_wdata > `ADSSQ_SCAN_LEN_MAX) begin
            scan_len_next = `ADSSQ_SCAN_LEN_FULL;
         end else begin
            scan_len_next = bus_wdata[4:0];
         end
      end
   end

   // sequencer
   always @* begin
      state_next      = state_reg;
      kind_next       = kind_reg;
      chan_next       = chan_reg;
      conv_start_next = 1'b0;
      conv_chan_next  = conv_chan;
      store_en        = 1'b0;
      result_next     = result_reg;
      ready_next      = ready_reg;
      scan_done_next  = scan_done_reg;
      case (state_reg)
         ST_IDLE: begin
            if (halt) begin
               // R22 halted sequencer stays idle
               state_next = ST_IDLE;
            end else if (op_mode == `ADSSQ_OP_AUTO) begin
               // R01 free-running scan starts by itself
               kind_next  = KIND_AUTO;
               chan_next  = 4'd0;
               state_next = ST_START;
            end else if (start_single) begin
               // R06 single pass begins at channel zero
               kind_next      = KIND_SINGLE;
               chan_next      = 4'd0;
               // R25 clear stale completion
               scan_done_next = 1'b0;
               state_next     = ST_START;
            end else if (start_poll) begin
               // R14 convert the selected channel
               kind_next  = KIND_POLL;
               chan_next  = bus_wdata[3:0];
               // R25 clear stale completion
               ready_next = 1'b0;
               state_next = ST_START;
            end
            // R24 both mode bits set: nothing starts
         end
         ST_START: begin
            // R22 halt before the pulse starts nothing
            if (halt) begin
               state_next = ST_IDLE;
            end else begin
               conv_start_next = 1'b1;
               conv_chan_next  = chan_reg;
               state_next      = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // R26 new starts ignored here
            if (conv_done) begin
               if (kind_reg == KIND_POLL) begin
                  // R18 result into converter register
                  result_next = fmt_word;
                  // R15 data ready
                  ready_next  = 1'b1;
                  state_next  = ST_IDLE;
               end else begin
                  // R03 scanned result to its channel
                  store_en = 1'b1;
                  if (halt) begin
                     // R22 halt stops the scan
                     state_next = ST_IDLE;
                  end else if (chan_reg >= last_chan) begin
                     if (kind_reg == KIND_SINGLE) begin
                        // R07 end of scan
                        scan_done_next = 1'b1;
                        state_next     = ST_IDLE;
                     end else if (op_mode == `ADSSQ_OP_AUTO) begin
                        // R02 wrap to channel zero
                        chan_next  = 4'd0;
                        state_next = ST_START;
                     end else begin
                        state_next = ST_IDLE;
                     end
                  end else if ((kind_reg == KIND_AUTO) && (op_mode != `ADSSQ_OP_AUTO)) begin
                     // mode changed mid scan: finish this sample and stop
                     state_next = ST_IDLE;
                  end else begin
                     // R02 ascending order
                     chan_next  = chan_reg + 4'd1;
                     state_next = ST_START;
                  end
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         // R01 reset enters free-running scan
         ctrl_reg      <= `ADSSQ_CTRL_RESET;
         // R11 sixteen channels after reset
         scan_len_reg  <= `ADSSQ_SCAN_LEN_FULL;
         result_reg    <= 16'h0000;
         ready_reg     <= 1'b0;
         scan_done_reg <= 1'b0;
         state_reg     <= ST_IDLE;
         kind_reg      <= KIND_AUTO;
         chan_reg      <= 4'h0;
         conv_start    <= 1'b0;
         conv_chan     <= 4'h0;
         settle_req    <= 1'b0;
      end else begin
         ctrl_reg      <= ctrl_next;
         scan_len_reg  <= scan_len_next;
         result_reg    <= result_next;
         ready_reg     <= ready_next;
         scan_done_reg <= scan_done_next;
         state_reg     <= state_next;
         kind_reg      <= kind_next;
         chan_reg      <= chan_next;
         conv_start    <= conv_start_next;
         conv_chan     <= conv_chan_next;
         settle_req    <= settle_next;
      end
   end

   // read multiplexer; unmapped offsets read zero
   always @* begin
      rd_word = 16'h0000;
      case (bus_addr)
         `ADSSQ_OFS_CTRL: begin
            rd_word = ctrl_view;
         end
         `ADSSQ_OFS_RESULT: begin
            rd_word = result_reg;
         end
         `ADSSQ_OFS_SCAN_LEN: begin
            rd_word = len_view;
         end
         default: begin
            if (chan_hit) begin
               // R04 read without stalling the scan
               rd_word = chan_rd_data;
            end
         end
      endcase
   end

   // register reads, answered one cycle after the strobe
   always @(posedge ref_clk) begin
      if (srst) begin
         bus_rdata  <= 16'h0000;
         bus_rvalid <= 1'b0;
      end else begin
         bus_rvalid <= bus_rd;
         if (bus_rd) begin
            // data holds until the next read
            bus_rdata <= rd_word;
         end
      end
   end

endmodule // adssq_seq

// File: adssq_seq_assertions.sv
// port assertions for the scan sequencer
`timescale 1ns/10ps
module adssq_seq_assertions (
   // clock and reset
   input wire        ref_clk,
   input wire        srst,
   // register port
   input wire [6:0]  bus_addr,
   input wire        bus_wr,
   input wire        bus_rd,
   input wire [15:0] bus_wdata,
   input wire [15:0] bus_rdata,
   input wire        bus_rvalid,
   // converter link
   input wire        conv_start,
   input wire [3:0]  conv_chan,
   input wire        conv_done,
   input wire        conv_busy
);
   reg  [1:0] mode_reg;
   reg        halt_reg;
   reg  [3:0] last_reg;
   wire       ctl_wr = bus_wr && bus_addr == 7'h02;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // shadow of mode and halt bits, last started channel
   always @(posedge ref_clk) begin
      if (srst) begin
         mode_reg <= 2'h0;
         halt_reg <= 1'h0;
         last_reg <= 4'h0;
      end else begin
         if (ctl_wr) begin
            mode_reg <= {bus_wdata[7], bus_wdata[4]};
            halt_reg <= bus_wdata[5];
         end
         if (conv_start)
            last_reg <= conv_chan;
      end
   end
   sequence s_done_quiet;
      conv_done && mode_reg == 2'h0 && !halt_reg && !bus_wr ##1 !bus_wr;
   endsequence
   sequence s_no_start;
      !conv_start [*3];
   endsequence
   property p_rd_ans;
      bus_rd |=> bus_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_rv_only;
      !bus_rd |=> !bus_rvalid;
   endproperty
   a_rv_only: assert property (p_rv_only) else $error("stray read answer");
   property p_start_pulse;
      conv_start |=> !conv_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start wider than a cycle");
   property p_chan_hold;
      !conv_start && !$past(srst) |-> $stable(conv_chan);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("channel moved without start");
   property p_reset_scan;
      $fell(srst) |-> ##2 conv_start && conv_chan == 4'h0;
   endproperty
   a_reset_scan: assert property (p_reset_scan) else $error("no scan of channel zero after reset");
   property p_ascend;
      conv_start && mode_reg != 2'h1 |-> conv_chan == 4'h0 || conv_chan == last_reg + 4'h1;
   endproperty
   a_ascend: assert property (p_ascend) else $error("scan order broken");
   property p_auto_next;
      s_done_quiet |=> conv_start;
   endproperty
   a_auto_next: assert property (p_auto_next) else $error("free scan did not continue");
   property p_mode_none;
      ctl_wr && bus_wdata[7] && bus_wdata[4] && !conv_busy && (mode_reg != 2'h0 || halt_reg) |=> s_no_start;
   endproperty
   a_mode_none: assert property (p_mode_none) else $error("undefined mode started");
   property p_len_halt;
      bus_rd && bus_addr == 7'h06 && halt_reg |=> bus_rdata == 16'h0010;
   endproperty
   a_len_halt: assert property (p_len_halt) else $error("halt did not force length");
endmodule // adssq_seq_assertions

bind adssq_seq adssq_seq_assertions adssq_seq_assertions_i (
   .ref_clk(ref_clk), .srst(srst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .conv_start(conv_start),
   .conv_chan(conv_chan), .conv_done(conv_done), .conv_busy(conv_busy)
);

// File: testbench.sv
// self-checking testbench for the scan sequencer
`timescale 1ns/10ps
module testbench;
   localparam [47:0] BASES = 48'h7f0_80a_ffa_000;
   localparam [63:0] EXPS  = 64'h07ff_0800_07ff_f800;
   localparam [15:0] CHS   = 16'hfa50;
   reg         ref_clk = 1'b0;
   reg         srst = 1'b1;
   reg  [6:0]  bus_addr = 7'h00;
   reg         bus_wr = 1'b0;
   reg         bus_rd = 1'b0;
   reg  [15:0] bus_wdata = 16'h0000;
   reg  [11:0] base = 12'h000;
   wire [15:0] bus_rdata;
   wire        bus_rvalid, conv_start, conv_done, conv_busy;
   wire [3:0]  conv_chan;
   wire [11:0] conv_data;
   wire [1:0]  test_mode;
   wire        settle_req, fail_led_on, outputs_online, fast_refresh, short_settle;
   integer     error_cnt = 0;
   integer     n_checks = 0;
   integer     n_starts = 0;
   integer     i, j, k, s, ns;

   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (conv_start === 1'b1)
         n_starts <= n_starts + 1;

   adssq_seq adssq_seq_i (
      .ref_clk(ref_clk), .srst(srst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .conv_start(conv_start),
      .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data), .settle_req(settle_req),
      .conv_busy(conv_busy), .fail_led_on(fail_led_on), .outputs_online(outputs_online),
      .test_mode(test_mode), .fast_refresh(fast_refresh), .short_settle(short_settle)
   );
   adssq_conv_model adssq_conv_model_i (
      .ref_clk(ref_clk), .conv_start(conv_start), .conv_chan(conv_chan), .base(base),
      .conv_done(conv_done), .conv_data(conv_data)
   );

   function [15:0] tc(input [11:0] c);
      tc = {{4{~c[11]}}, ~c[11], c[10:0]};
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [6:0] a, input [15:0] d);
      begin
         bus_addr <= a;
         bus_wdata <= d;
         bus_wr <= 1'b1;
         @(posedge ref_clk);
         bus_wr <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task rd(input [6:0] a, input [15:0] m, input [15:0] e);
      begin
         bus_addr <= a;
         bus_rd <= 1'b1;
         @(posedge ref_clk);
         bus_rd <= 1'b0;
         #1;
         chk({15'h0, bus_rvalid}, 16'h0001);
         chk(bus_rdata & m, e);
         @(posedge ref_clk);
      end
   endtask
   task wait_starts(input integer n);
      begin
         s = n_starts;
         for (i = 0; i < 3000 && n_starts < s + n; i = i + 1)
            @(posedge ref_clk);
         chk({15'h0, n_starts >= s + n}, 16'h0001);
      end
   endtask
   task wait_idle;
      begin
         i = 0;
         @(posedge ref_clk);
         #1;
         while (conv_busy !== 1'b0 && i < 500) begin
            @(posedge ref_clk);
            #1;
            i = i + 1;
         end
         chk({15'h0, conv_busy}, 16'h0000);
      end
   endtask

   task t_reset;
      begin
         chk({9'h000, settle_req, short_settle, fail_led_on, outputs_online, test_mode, fast_refresh}, 16'h0010);
         rd(7'h06, 16'hffff, 16'h0010);
         rd(7'h04, 16'hffff, 16'h0000);
         rd(7'h60, 16'hffff, 16'h0000);
      end
   endtask
   task t_auto;
      begin
         base <= 12'h5a0;
         wait_starts(40);
         for (k = 0; k < 16; k = k + 1)
            rd(7'h40 + {k[5:0], 1'b0}, 16'hffff, tc(12'h5a0 ^ k[11:0]));
         base <= 12'h0f3;
         wait_starts(40);
         for (k = 0; k < 16; k = k + 1)
            rd(7'h40 + {k[5:0], 1'b0}, 16'hffff, tc(12'h0f3 ^ k[11:0]));
      end
   endtask
   task t_halt;
      begin
         wr(7'h02, 16'h00a0);
         wait_idle;
         wr(7'h06, 16'h0005);
         rd(7'h06, 16'hffff, 16'h0010);
         wr(7'h02, 16'h0080);
         wr(7'h06, 16'h0011);
         rd(7'h06, 16'hffff, 16'h0010);
         wr(7'h06, 16'h0003);
         rd(7'h06, 16'hffff, 16'h0003);
      end
   endtask
   task t_single;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            base <= 12'h800 ^ {k[7:0], 4'h0};
            ns = n_starts;
            wr(7'h02, 16'h2080);
            rd(7'h02, 16'h2000, 16'h0000);
            wr(7'h02, 16'h2080);
            wait_idle;
            chk(n_starts[15:0] - ns[15:0], k ? 16'h0001 : 16'h0003);
            rd(7'h02, 16'h2000, 16'h2000);
            for (j = 0; j < 4; j = j + 1)
               rd(7'h40 + {j[5:0], 1'b0}, 16'hffff,
                  tc(j == 3 ? 12'h0f0 : (k == 1 && j == 0) ? 12'h810 : 12'h800 ^ j[11:0]));
            wr(7'h06, 16'h0000);
         end
      end
   endtask
   task t_poll;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            base <= BASES[k * 12 +: 12];
            wr(7'h02, {3'h1, k[1], 8'h01, CHS[k * 4 +: 4]});
            rd(7'h02, 16'h8000, 16'h0000);
            wait_idle;
            chk({12'h000, conv_chan}, {12'h000, CHS[k * 4 +: 4]});
            rd(7'h02, 16'h8000, 16'h8000);
            rd(7'h04, 16'hffff, EXPS[k * 16 +: 16]);
         end
         wr(7'h04, 16'h1234);
         rd(7'h04, 16'hffff, 16'h07ff);
         ns = n_starts;
         wr(7'h02, 16'h2090);
         rd(7'h02, 16'h0090, 16'h0090);
         chk(n_starts[15:0] - ns[15:0], 16'h0000);
         wr(7'h02, 16'h0000);
         wait_starts(20);
      end
   endtask

   task t_board;
      begin
         bus_addr <= 7'h02;
         bus_wdata <= 16'hcdd0;
         bus_wr <= 1'b1;
         @(posedge ref_clk);
         bus_wr <= 1'b0;
         #1;
         chk({9'h000, settle_req, short_settle, fail_led_on, outputs_online, test_mode, fast_refresh}, 16'h006d);
         @(posedge ref_clk);
         #1;
         chk({15'h0, settle_req}, 16'h0000);
         @(posedge ref_clk);
         rd(7'h02, 16'h5fff, 16'h4d90);
      end
   endtask

   task finish_test;
      begin
         $display("checks %0d errors %0d", n_checks, error_cnt);
         if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   initial begin
      #400000;
      error_cnt = error_cnt + 1;
      finish_test;
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      t_reset;
      t_auto;
      t_halt;
      t_single;
      t_poll;
      t_board;
      finish_test;
   end
endmodule // testbench
